/* bench/oam_ctrl_bench.sv */
/*
 * oam_ctrl_bench: directed sequences on the config and trim ports of oam_ctrl.
 * assumes: oam_pkg and oam_far_model compiled first; outputs lag inputs by one edge.
 */
`timescale 1ns/10ps

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module oam_ctrl_bench;
    import oam_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic                  clk, rst, ce, port_drive_oe, trim_wr, lvl;
    oam_cfg_t              cfg, c;          // c is staged, cfg driven
    logic [3:0]            override_src;
    logic [1:0]            adc_positive_channel, ach;
    logic [OAM_TRIM_W-1:0] trim_wdata, offset_trim;
    logic                  amp_power_on, amp_output_pin_oe, pd, lv, eff;
    oam_mode_t             mode;
    oam_route_t            route;
    int                    errors, total_checks, i;
    oam_mode_t             swm [4] = '{OAM_MODE_BASIC, OAM_MODE_GND, OAM_MODE_SUPPLY, OAM_MODE_BASIC};
    oam_nsrc_t             nexp [8] = '{OAM_NSRC_GND, OAM_NSRC_LADDER, OAM_NSRC_PIN, OAM_NSRC_HALF,
                                        OAM_NSRC_DAC1, OAM_NSRC_DAC2, OAM_NSRC_OPEN, OAM_NSRC_OPEN};

    oam_ctrl dut (.clk(clk), .rst(rst), .ce(ce), .cfg(cfg), .override_src(override_src),
        .port_drive_oe(port_drive_oe), .adc_positive_channel(adc_positive_channel),
        .trim_wr(trim_wr), .trim_wdata(trim_wdata), .amp_power_on(amp_power_on),
        .amp_output_pin_oe(amp_output_pin_oe), .mode(mode), .route(route), .offset_trim(offset_trim));

    oam_far_model far (.clk(clk), .rst(rst), .level(lvl), .sel(cfg.override_source_sel),
        .override_src(override_src));

    ////////////////////////////////////////////////////////////////////////
    // 200 mhz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // launch staged inputs, let one edge take them, look once settled
    task automatic step;
        @(posedge clk);
        cfg <= c;
        port_drive_oe <= pd;
        lvl <= lv;
        adc_positive_channel <= ach;
        @(posedge clk);
        #1;
    endtask : step

    task automatic endt(input string n);
        $display("test %s done", n);
    endtask : endt

    task automatic close_out;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        cfg = '0;
        c = '0;
        pd = 1'b1;
        lv = 1'b0;
        ach = 2'h0;
        port_drive_oe = 1'b0;
        trim_wr = 1'b0;
        trim_wdata = 8'h00;
        lvl = 1'b0;
        adc_positive_channel = 2'h0;
        errors = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        `CHK(offset_trim, OAM_TRIM_RST)
        // gpio may drive only while the amp is off
        step;
        `CHK(amp_output_pin_oe, 1'b1)
        `CHK(amp_power_on, 1'b0)
        c.amp_en = 1'b1;
        step;
        `CHK(amp_output_pin_oe, 1'b0)
        `CHK(amp_power_on, 1'b1)
        endt("enable");
        // every software output code, then unity feedback
        for (i = 0; i < 4; i++) begin
            c.sw_out_ctl = i[1:0];
            step;
            `CHK(mode, swm[i])
        end
        c.sw_out_ctl = OAM_OUT_BASIC;
        c.unity_feedback_sel = 1'b1;
        step;
        `CHK(mode, OAM_MODE_UNITY)
        `CHK(route.inv_src, OAM_ISRC_OUTPUT)
        `CHK(route.inv_pin_release, 1'b1)
        c.unity_feedback_sel = 1'b0;
        endt("software mode");
        // all noninverting codes; pin pick shows only for the pin code
        c.noninv_pin_sel = 2'h3;
        for (i = 0; i < 8; i++) begin
            c.noninv_channel_sel = i[2:0];
            step;
            `CHK(route.noninv_src, nexp[i])
            `CHK(route.noninv_pin, (i == 2) ? 2'h3 : 2'h0)
        end
        c.inv_channel_sel = OAM_ICH_PIN;
        c.inv_pin_sel = 2'h2;
        step;
        `CHK(route.inv_src, OAM_ISRC_PIN)
        `CHK(route.inv_pin, 2'h2)
        c.inv_channel_sel = OAM_ICH_LADDER;
        c.gain_select = 3'h5;
        step;
        `CHK(route.inv_src, OAM_ISRC_LADDER)
        `CHK(route.gain, 3'h0)
        c.ladder_enable = 1'b1;
        step;
        `CHK(route.gain, 3'h5)
        `CHK(route.ladder_on, 1'b1)
        endt("routing");
        // override: every line, both polarities, both levels; software field ignored
        c.override_enable = 1'b1;
        c.mode_when_high = OAM_HW_RAIL;
        c.mode_when_low = OAM_HW_UNITY;
        c.sw_out_ctl = OAM_OUT_GND;
        for (i = 0; i < 16; i++) begin
            c.override_source_sel = i[1:0];
            c.override_invert = i[2];
            lv = i[3];
            eff = i[3] ^ i[2];
            step;
            `CHK(mode, eff ? OAM_MODE_SUPPLY : OAM_MODE_UNITY)
            `CHK(route.inv_pin_release, !eff)
        end
        c.mode_when_low = OAM_HW_BASIC;
        step;
        `CHK(mode, OAM_MODE_BASIC)
        // rail from the low field at low effective level drives to ground
        c.mode_when_low = OAM_HW_RAIL;
        step;
        `CHK(mode, OAM_MODE_GND)
        c.override_enable = 1'b0;
        endt("override");
        // adc mode picks the pin through the adc channel
        c.adc_mode = 1'b1;
        c.noninv_channel_sel = OAM_NCH_PIN;
        ach = 2'h1;
        step;
        `CHK(route.adc_route, 1'b1)
        `CHK(route.noninv_pin, 2'h1)
        endt("adc");
        // recalibration: unity on a pin reference, then adc mode routes the output to the adc and takes the pin pick from the adc channel
        c.adc_mode = 1'b0;
        c.sw_out_ctl = OAM_OUT_BASIC;
        c.unity_feedback_sel = 1'b1;
        step;
        `CHK(mode, OAM_MODE_UNITY)
        `CHK(route.noninv_pin, 2'h3)
        c.adc_mode = 1'b1;
        ach = 2'h2;
        step;
        `CHK(route.adc_route, 1'b1)
        `CHK(route.noninv_pin, 2'h2)
        endt("calibration");
        // trim: back-to-back extremes, frozen write, reset reload
        @(posedge clk);
        trim_wr <= 1'b1;
        trim_wdata <= 8'h00;
        @(posedge clk);
        trim_wdata <= 8'hff;
        #1 `CHK(offset_trim, 8'h00)
        @(posedge clk);
        ce <= 1'b0;
        trim_wdata <= 8'h3c;
        #1 `CHK(offset_trim, 8'hff)
        @(posedge clk);
        ce <= 1'b1;
        trim_wr <= 1'b0;
        #1 `CHK(offset_trim, 8'hff)
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1 `CHK(offset_trim, OAM_TRIM_RST)
        endt("trim");
        close_out();
    end
endmodule : oam_ctrl_bench

/* bench/oam_far_model.sv */
/*
 * oam_far_model: far side of the op_amp control, the candidate override lines.
 * assumes: the bench gives the wanted level and the line that the block listens to.
 */
`timescale 1ns/10ps

module oam_far_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       level,
    input  wire logic [1:0] sel,
    output logic      [3:0] override_src
);
    ////////////////////////////////////////////////////////////////////////
    logic [3:0] noise_reg; // unselected lines, toggling

    // idle lines flip every cycle so that a wrong line pick cannot pass
    always_ff @(posedge clk) begin
        if (rst) noise_reg <= 4'h5;
        else noise_reg <= ~noise_reg;
    end

    // only the chosen line carries the wanted level
    always_comb begin
        override_src = noise_reg;
        override_src[sel] = level;
    end
endmodule : oam_far_model

/* hw/oam_ctrl.sv */
/*
 * oam_ctrl: digital mode, routing, pin and trim control of the op_amp.
 * assumes: all inputs synchronous to clk; analog switches follow the registered outputs.
 */
//
// Contract
// - enabled amp tri-states the ordinary pin driver
// - override off: mode from software output control
// - noninv source from channel field, pin select
// - inv source from channel field, pin select
// - ladder enable gates gain select
// - channel fields can route ladder either input
// - unity bit ties output to inverting input
// - override enable uses selected override source
// - high field when signal high, else low
// - invert bit swaps the two fields
// - override modes: basic, unity, rail drive
// - unity mode releases the inverting pin
// - trim writable, reset restores factory value
// - trim is unsigned, covers both offset signs
// - adc mode routes output to adc
// - output control 00 basic, 01 gnd, 10 supply
// - noninv channel codes decode as listed
// - clearing enable powers amp down
`timescale 1ns/10ps

module oam_ctrl
    import oam_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    input  wire oam_cfg_t              cfg,
    input  wire logic [3:0]            override_src,
    input  wire logic                  port_drive_oe,
    input  wire logic [1:0]            adc_positive_channel,
    input  wire logic                  trim_wr,
    input  wire logic [OAM_TRIM_W-1:0] trim_wdata,
    output logic                       amp_power_on,
    output logic                       amp_output_pin_oe,
    output oam_mode_t                  mode,
    output oam_route_t                 route,
    output logic [OAM_TRIM_W-1:0]      offset_trim
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    ////////////////////////////////////////////////////////////////////////////
    oam_mode_t             mode_reg, mode_next;       // effective mode
    oam_route_t            route_reg, route_next;     // switch settings
    logic                  power_reg, power_next;     // amp bias on
    logic                  pin_oe_reg, pin_oe_next;   // digital driver gate
    logic [OAM_TRIM_W-1:0] trim_reg, trim_next;       // offset trim code
    logic                  ovr_level;                 // override after invert
    logic [2:0]            hw_code;                   // chosen override field

    ////////////////////////////////////////////////////////////////////////////
    // mode selection
    ////////////////////////////////////////////////////////////////////////////
    // picks software or override mode; registered, so a level change lands next edge
    always_comb begin
        // selected source, polarity applied
        ovr_level = override_src[cfg.override_source_sel] ^ cfg.override_invert;
        hw_code   = ovr_level ? cfg.mode_when_high : cfg.mode_when_low;
        mode_next = OAM_MODE_BASIC;
        if (cfg.override_enable) begin
            // hardware override path
            case (hw_code)
                OAM_HW_UNITY: mode_next = OAM_MODE_UNITY;
                // rail follows the override level and polarity
                OAM_HW_RAIL:  mode_next = ovr_level ? OAM_MODE_SUPPLY : OAM_MODE_GND;
                default:      mode_next = OAM_MODE_BASIC;
            endcase
        end else begin
            // software path
            case (cfg.sw_out_ctl)
                OAM_OUT_GND:    mode_next = OAM_MODE_GND;
                OAM_OUT_SUPPLY: mode_next = OAM_MODE_SUPPLY;
                // basic, and reserved 11 treated as basic rather than a rail
                default: mode_next = cfg.unity_feedback_sel ? OAM_MODE_UNITY : OAM_MODE_BASIC;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source routing
    ////////////////////////////////////////////////////////////////////////////
    // channel decode, pin selects, ladder and adc path
    always_comb begin
        route_next = '0;
        // noninverting channel decode
        case (cfg.noninv_channel_sel)
            OAM_NCH_GND:    route_next.noninv_src = OAM_NSRC_GND;
            OAM_NCH_LADDER: route_next.noninv_src = OAM_NSRC_LADDER;
            OAM_NCH_PIN:    route_next.noninv_src = OAM_NSRC_PIN;
            OAM_NCH_HALF:   route_next.noninv_src = OAM_NSRC_HALF;
            OAM_NCH_DAC1:   route_next.noninv_src = OAM_NSRC_DAC1;
            OAM_NCH_DAC2:   route_next.noninv_src = OAM_NSRC_DAC2;
            default:        route_next.noninv_src = OAM_NSRC_OPEN; // reserved
        endcase
        // inverting channel decode
        case (cfg.inv_channel_sel)
            OAM_ICH_LADDER: route_next.inv_src = OAM_ISRC_LADDER;
            OAM_ICH_PIN:    route_next.inv_src = OAM_ISRC_PIN;
            OAM_ICH_DAC1:   route_next.inv_src = OAM_ISRC_DAC1;
            OAM_ICH_DAC2:   route_next.inv_src = OAM_ISRC_DAC2;
            default:        route_next.inv_src = OAM_ISRC_OPEN;
        endcase
        // unity feedback overrides the inverting channel and frees the pin
        if (mode_next == OAM_MODE_UNITY) begin
            route_next.inv_src         = OAM_ISRC_OUTPUT;
            route_next.inv_pin_release = 1'b1;
        end
        // pin selects only matter when a pin is the source
        if (route_next.noninv_src == OAM_NSRC_PIN) begin
            route_next.noninv_pin = cfg.noninv_pin_sel;
        end
        if (route_next.inv_src == OAM_ISRC_PIN) begin
            route_next.inv_pin = cfg.inv_pin_sel;
        end
        // adc mode: adc channel choice wins over the pin select
        if (cfg.adc_mode) begin
            route_next.adc_route = 1'b1;
            if (route_next.noninv_src == OAM_NSRC_PIN) begin
                route_next.noninv_pin = adc_positive_channel;
            end
        end
        // gain only meaningful with the ladder up
        route_next.ladder_on = cfg.ladder_enable;
        route_next.gain      = cfg.ladder_enable ? cfg.gain_select : 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // power, pin driver and trim
    ////////////////////////////////////////////////////////////////////////////
    // enable also blocks the digital driver so the two never fight
    always_comb begin
        power_next  = cfg.amp_en;
        pin_oe_next = port_drive_oe & ~cfg.amp_en;
        // unsigned code, mid value is zero correction
        trim_next   = trim_wr ? trim_wdata : trim_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    ////////////////////////////////////////////////////////////////////////////
    // reset reloads the factory trim, discarding software writes
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg   <= OAM_MODE_BASIC;
            route_reg  <= '{noninv_src: OAM_NSRC_GND, inv_src: OAM_ISRC_OPEN, default: '0};
            power_reg  <= 1'b0;
            pin_oe_reg <= 1'b0;
            trim_reg   <= OAM_TRIM_RST;
        end else if (ce) begin
            mode_reg   <= mode_next;
            route_reg  <= route_next;
            power_reg  <= power_next;
            pin_oe_reg <= pin_oe_next;
            trim_reg   <= trim_next;
        end
    end

    // outputs straight from flops
    assign mode              = mode_reg;
    assign route             = route_reg;
    assign amp_power_on      = power_reg;
    assign amp_output_pin_oe = pin_oe_reg;
    assign offset_trim       = trim_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    // every check sleeps through reset except the reload check, which opts out
    default disable iff (rst);

    // amp on: digital driver off, bias on
    a_pin_tristate: assert property (ce && cfg.amp_en |=> !amp_output_pin_oe && amp_power_on)
        else $error("pin driver active while amp enabled");

    // amp off: the port's drive wish passes straight through
    a_pin_follow: assert property (ce && !cfg.amp_en |=> amp_output_pin_oe == $past(port_drive_oe))
        else $error("pin drive wish not passed through");

    // amp off: no bias current
    a_power_off: assert property (ce && !cfg.amp_en |=> !amp_power_on)
        else $error("amp powered while disabled");

    // software ground drive
    a_sw_mode: assert property (ce && !cfg.override_enable && cfg.sw_out_ctl == OAM_OUT_GND
        |=> mode == OAM_MODE_GND)
        else $error("software ground mode not applied");

    // software supply drive
    a_sw_supply: assert property (ce && !cfg.override_enable && cfg.sw_out_ctl == OAM_OUT_SUPPLY
        |=> mode == OAM_MODE_SUPPLY)
        else $error("software supply mode not applied");

    // noninverting pin select followed outside adc mode
    a_noninv_pin: assert property (ce && cfg.noninv_channel_sel == OAM_NCH_PIN && !cfg.adc_mode
        |=> route.noninv_src == OAM_NSRC_PIN && route.noninv_pin == $past(cfg.noninv_pin_sel))
        else $error("noninverting pin select not followed");

    // pin pick reads zero unless a pin is the source
    a_noninv_pin_idle: assert property (ce && cfg.noninv_channel_sel != OAM_NCH_PIN
        |=> route.noninv_pin == 2'h0)
        else $error("noninverting pin pick leaked");

    // reserved noninverting codes leave the input open
    a_noninv_rsvd: assert property (ce && cfg.noninv_channel_sel > OAM_NCH_DAC2
        |=> route.noninv_src == OAM_NSRC_OPEN)
        else $error("reserved noninverting code not open");

    // ladder reachable on the noninverting side
    a_ladder_noninv: assert property (ce && cfg.noninv_channel_sel == OAM_NCH_LADDER
        |=> route.noninv_src == OAM_NSRC_LADDER)
        else $error("ladder not on noninverting input");

    // ladder reachable on the inverting side while unity is off
    a_ladder_inv: assert property (ce && cfg.inv_channel_sel == OAM_ICH_LADDER && !cfg.override_enable
        && !cfg.unity_feedback_sel |=> route.inv_src == OAM_ISRC_LADDER)
        else $error("ladder not on inverting input");

    // inverting pin select followed while unity is off
    a_inv_pin: assert property (ce && cfg.inv_channel_sel == OAM_ICH_PIN && !cfg.override_enable
        && !cfg.unity_feedback_sel |=> route.inv_src == OAM_ISRC_PIN && route.inv_pin == $past(cfg.inv_pin_sel))
        else $error("inverting pin select not followed");

    // no connection code leaves the inverting input open
    a_inv_open: assert property (ce && cfg.inv_channel_sel == OAM_ICH_NONE && !cfg.override_enable
        && !cfg.unity_feedback_sel |=> route.inv_src == OAM_ISRC_OPEN)
        else $error("inverting input not open");

    // gain field follows the ladder enable
    a_gain_gate: assert property (ce |=> route.gain == ($past(cfg.ladder_enable) ?
        $past(cfg.gain_select) : 3'h0))
        else $error("gain not gated by ladder enable");

    // ladder off: gain field held at zero
    a_gain_off: assert property (ce && !cfg.ladder_enable |=> !route.ladder_on && route.gain == 3'h0)
        else $error("gain live with ladder off");

    // software unity ties output to the inverting input
    a_unity_sw: assert property (ce && !cfg.override_enable && cfg.sw_out_ctl == OAM_OUT_BASIC
        && cfg.unity_feedback_sel |=> route.inv_src == OAM_ISRC_OUTPUT && route.inv_pin_release)
        else $error("unity feedback not connected");

    // unity, from either path, always carries its feedback and pin release
    a_unity_release: assert property (mode == OAM_MODE_UNITY
        |-> route.inv_src == OAM_ISRC_OUTPUT && route.inv_pin_release)
        else $error("unity mode without feedback or pin release");

    // plain high line picks the high field
    a_ovr_high: assert property (ce && cfg.override_enable && !cfg.override_invert
        && override_src[cfg.override_source_sel] && cfg.mode_when_high == OAM_HW_UNITY
        |=> mode == OAM_MODE_UNITY)
        else $error("high field not applied");

    // plain low line picks the low field
    a_ovr_low: assert property (ce && cfg.override_enable && !cfg.override_invert
        && !override_src[cfg.override_source_sel] && cfg.mode_when_low == OAM_HW_UNITY
        |=> mode == OAM_MODE_UNITY)
        else $error("low field not applied");

    // inverted low line picks the high field
    a_ovr_invert: assert property (ce && cfg.override_enable && cfg.override_invert
        && !override_src[cfg.override_source_sel] && cfg.mode_when_high == OAM_HW_RAIL
        |=> mode == OAM_MODE_SUPPLY)
        else $error("inverted override wrong");

    // inverted high line picks the low field: basic
    a_ovr_basic: assert property (ce && cfg.override_enable && cfg.override_invert
        && override_src[cfg.override_source_sel] && cfg.mode_when_low == OAM_HW_BASIC
        |=> mode == OAM_MODE_BASIC)
        else $error("override basic mode not applied");

    // rail from the low field drives to ground
    a_rail_low: assert property (ce && cfg.override_enable && cfg.override_invert
        && override_src[cfg.override_source_sel] && cfg.mode_when_low == OAM_HW_RAIL
        |=> mode == OAM_MODE_GND)
        else $error("rail drive not to ground at low level");

    // reset reloads trim and mode even with a write or ce low pending
    a_trim_reset: assert property (disable iff (1'b0) rst |=> offset_trim == OAM_TRIM_RST
        && mode == OAM_MODE_BASIC)
        else $error("trim not reloaded on reset");

    // a write lands and then holds while nothing else writes
    a_trim_write: assert property (ce && trim_wr ##1 !(ce && trim_wr) [*2]
        |-> offset_trim == $past(trim_wdata, 2))
        else $error("trim write lost");

    // clock enable low freezes mode and trim, a pending write included
    a_ce_freeze: assert property (!ce |=> $stable(mode) && $stable(offset_trim))
        else $error("state moved while clock enable low");

    // adc mode routes the output to the converter
    a_adc_route: assert property (ce && cfg.adc_mode |=> route.adc_route)
        else $error("adc routing missing");

    // adc channel pick replaces the pin select
    a_adc_pin: assert property (ce && cfg.adc_mode && cfg.noninv_channel_sel == OAM_NCH_PIN
        |=> route.noninv_pin == $past(adc_positive_channel))
        else $error("adc channel pick not applied");

    // main scenarios the bench should reach
    c_override_rail: cover property (ce && cfg.override_enable ##1 mode == OAM_MODE_SUPPLY);
    c_unity_hw:      cover property (ce && cfg.override_enable ##1 mode == OAM_MODE_UNITY);
    c_trim_written:  cover property (ce && trim_wr ##1 offset_trim != OAM_TRIM_RST);
    c_unity_sw:      cover property (ce && cfg.unity_feedback_sel ##1 route.inv_pin_release);
    c_adc_pin:       cover property (ce && cfg.adc_mode ##1 route.adc_route);

endmodule : oam_ctrl

/* hw/oam_pkg.sv */
/*
 * oam_pkg: shared constants, codes and carriers for the op_amp mode control.
 * assumes: one clock, synchronous active-high reset, software fields arrive as plain ports.
 */
package oam_pkg;

    // software output control field codes
    localparam logic [1:0] OAM_OUT_BASIC   = 2'h0; // user or unity feedback
    localparam logic [1:0] OAM_OUT_GND     = 2'h1; // output to ground
    localparam logic [1:0] OAM_OUT_SUPPLY  = 2'h2; // output to supply

    // noninverting channel field codes
    localparam logic [2:0] OAM_NCH_GND     = 3'h0;
    localparam logic [2:0] OAM_NCH_LADDER  = 3'h1;
    localparam logic [2:0] OAM_NCH_PIN     = 3'h2;
    localparam logic [2:0] OAM_NCH_HALF    = 3'h3;
    localparam logic [2:0] OAM_NCH_DAC1    = 3'h4;
    localparam logic [2:0] OAM_NCH_DAC2    = 3'h5;

    // inverting channel field codes
    localparam logic [2:0] OAM_ICH_NONE    = 3'h0;
    localparam logic [2:0] OAM_ICH_LADDER  = 3'h1;
    localparam logic [2:0] OAM_ICH_PIN     = 3'h2;
    localparam logic [2:0] OAM_ICH_DAC1    = 3'h4;
    localparam logic [2:0] OAM_ICH_DAC2    = 3'h5;

    // override configuration field codes (high and low level fields alike)
    localparam logic [2:0] OAM_HW_BASIC    = 3'h0;
    localparam logic [2:0] OAM_HW_UNITY    = 3'h1;
    localparam logic [2:0] OAM_HW_RAIL     = 3'h2;

    // offset trim width and factory value reloaded on every reset
    localparam int         OAM_TRIM_W      = 8;
    localparam logic [7:0] OAM_TRIM_RST    = 8'h80;

    // effective operating mode, one-hot
    typedef enum logic [3:0] {
        OAM_MODE_BASIC  = 4'h1,
        OAM_MODE_UNITY  = 4'h2,
        OAM_MODE_GND    = 4'h4,
        OAM_MODE_SUPPLY = 4'h8
    } oam_mode_t;

    // noninverting source actually connected, one-hot
    typedef enum logic [6:0] {
        OAM_NSRC_GND    = 7'h01,
        OAM_NSRC_LADDER = 7'h02,
        OAM_NSRC_PIN    = 7'h04,
        OAM_NSRC_HALF   = 7'h08,
        OAM_NSRC_DAC1   = 7'h10,
        OAM_NSRC_DAC2   = 7'h20,
        OAM_NSRC_OPEN   = 7'h40
    } oam_nsrc_t;

    // inverting source actually connected, one-hot
    typedef enum logic [5:0] {
        OAM_ISRC_OPEN   = 6'h01,
        OAM_ISRC_LADDER = 6'h02,
        OAM_ISRC_PIN    = 6'h04,
        OAM_ISRC_DAC1   = 6'h08,
        OAM_ISRC_DAC2   = 6'h10,
        OAM_ISRC_OUTPUT = 6'h20
    } oam_isrc_t;

    // software configuration bundle
    typedef struct packed {
        logic       amp_en;
        logic       unity_feedback_sel;
        logic [1:0] sw_out_ctl;
        logic       ladder_enable;
        logic [2:0] gain_select;
        logic [2:0] noninv_channel_sel;
        logic [2:0] inv_channel_sel;
        logic [1:0] noninv_pin_sel;
        logic [1:0] inv_pin_sel;
        logic       override_enable;
        logic [1:0] override_source_sel;
        logic [2:0] mode_when_high;
        logic [2:0] mode_when_low;
        logic       override_invert;
        logic       adc_mode;
    } oam_cfg_t;

    // routing bundle handed to the analog switches
    typedef struct packed {
        oam_nsrc_t  noninv_src;
        oam_isrc_t  inv_src;
        logic [1:0] noninv_pin;
        logic [1:0] inv_pin;
        logic       inv_pin_release;
        logic       ladder_on;
        logic [2:0] gain;
        logic       adc_route;
    } oam_route_t;

endpackage : oam_pkg
